/* File: core/cfg_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module cfg_regs #(
	parameter logic [15:0] MAKER_ID = 16'h5a5a // arbitrary value
) (
	input  wire logic          CLK,
	input  wire logic          RST,
	input  wire logic          SCLK,
	input  wire logic          CS_N,
	input  wire logic          SDI,
	output logic               SDO,
	input  wire logic [23:0]   ALIGN_EDGE_POSITION,
	output var cfg_pkg::cfg_s  CFG,
	output logic               CHIP_RESET
);
	import cfg_pkg::*;

	logic [2:0]  pins_s;
	logic        sclk_s, csn_s, sdi_s;
	logic        sclk_p_q, csn_p_q;
	logic        sclk_rise, sclk_fall, cs_fall, cs_rise;
	spi_state_e  state_q;
	logic [3:0]  bit_cnt_q;
	logic [15:0] shift_q;
	logic        rw_q;
	logic [14:0] addr_q;
	logic [7:0]  rd_q;
	logic        wr_seen_q;
	logic [7:0]  if_cfg_q, mode_q, stream_q, align_q;
	logic [7:0]  if_cfg_st_q, mode_st_q, stream_st_q, align_st_q;
	logic [6:0]  rst_cnt_q;
	logic        busy, byte_end, wr_byte, commit, commit_reset, hdr_end;
	logic [7:0]  wr_data;
	logic [14:0] hdr_addr;

	// the pins come from the host's domain
	pin_sync #(.W(3), .INIT(3'b010)) pin_sync_i (
		.CLK (CLK),
		.RST (RST),
		.d   ({SCLK, CS_N, SDI}),
		.q   (pins_s)
	);
	assign {sclk_s, csn_s, sdi_s} = pins_s;

	// edge finding on the synchronised pins
	always_ff @(posedge CLK) begin
		if (RST) begin
			sclk_p_q <= 1'b0;
			csn_p_q  <= 1'b1;
		end else begin
			sclk_p_q <= sclk_s;
			csn_p_q  <= csn_s;
		end
	end
	assign sclk_rise = sclk_s & ~sclk_p_q;
	assign sclk_fall = ~sclk_s & sclk_p_q;
	assign cs_fall   = ~csn_s & csn_p_q;
	assign cs_rise   = csn_s & ~csn_p_q;

	// read decode, used at header end and at every byte boundary
	function automatic logic [7:0] read_byte(input logic [14:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_IF_CFG:   v = {1'b0, if_cfg_q[6:5], 1'b1, if_cfg_q[3:0]};
			ADDR_DEV_MODE: v = mode_q;
			ADDR_ID_LO:    v = MAKER_ID[7:0];
			ADDR_ID_HI:    v = MAKER_ID[15:8];
			ADDR_STREAM:   v = stream_q;
			ADDR_ALIGN:    v = align_q;
			ADDR_POS0:     v = ALIGN_EDGE_POSITION[7:0];
			ADDR_POS1:     v = ALIGN_EDGE_POSITION[15:8];
			ADDR_POS2:     v = ALIGN_EDGE_POSITION[23:16];
			default:       v = 8'h00;
		endcase
		return v;
	endfunction : read_byte

	// streaming address step
	function automatic logic [14:0] next_addr(input logic [14:0] a);
		logic [14:0] n;
		n = a;
		if (stream_q[STREAM_HOLD_BIT])
			n = a;
		else if (if_cfg_q[IF_ASCEND_BIT])
			n = 15'(a + 15'h1);
		else
			n = 15'(a - 15'h1);
		return n;
	endfunction : next_addr

	assign busy     = (rst_cnt_q != 7'h00);
	assign hdr_addr = {shift_q[13:0], sdi_s};
	assign hdr_end  = (state_q == S_HDR) && !csn_s && sclk_rise && (bit_cnt_q == HDR_LAST_BIT);
	assign byte_end = (state_q == S_DATA) && !csn_s && sclk_rise && (bit_cnt_q == BYTE_LAST_BIT);
	assign wr_byte  = byte_end && !rw_q;
	assign wr_data  = {shift_q[6:0], sdi_s};
	assign commit       = cs_rise && (state_q == S_DATA) && wr_seen_q;
	assign commit_reset = commit && if_cfg_st_q[IF_RESET_BIT];

	// serial framing: 1 read/write bit, 15 address bits, then data bytes
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q   <= S_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q   <= 16'h0000;
			rw_q      <= 1'b0;
			addr_q    <= 15'h0000;
			rd_q      <= 8'h00;
			wr_seen_q <= 1'b0;
		end else if (csn_s) begin
			state_q <= S_IDLE;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					// a frame opened during the reset quiet time is ignored whole
					if (cs_fall) begin
						state_q   <= busy ? S_SKIP : S_HDR;
						bit_cnt_q <= 4'h0;
						wr_seen_q <= 1'b0;
					end
				end
				S_HDR: begin
					if (sclk_rise) begin
						shift_q   <= {shift_q[14:0], sdi_s};
						bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
						if (hdr_end) begin
							rw_q      <= shift_q[14];
							addr_q    <= hdr_addr;
							rd_q      <= read_byte(hdr_addr);
							bit_cnt_q <= 4'h0;
							state_q   <= S_DATA;
						end
					end
				end
				S_DATA: begin
					if (sclk_rise) begin
						shift_q   <= {shift_q[14:0], sdi_s};
						bit_cnt_q <= 4'(bit_cnt_q + 4'h1);
						if (byte_end) begin
							bit_cnt_q <= 4'h0;
							wr_seen_q <= wr_seen_q | ~rw_q;
							addr_q    <= next_addr(addr_q);
							rd_q      <= read_byte(next_addr(addr_q));
						end
					end else if (sclk_fall) begin
						rd_q <= {rd_q[6:0], 1'b0};
					end
				end
				S_SKIP: state_q <= S_SKIP;
			endcase
		end
	end

	// read data only ever leaves on the separate output
	always_ff @(posedge CLK) begin
		if (RST || csn_s)
			SDO <= 1'b0;
		else if (state_q == S_DATA && rw_q && sclk_fall)
			SDO <= rd_q[7];
	end

	// staged copies: loaded at frame start, written per full byte
	always_ff @(posedge CLK) begin
		if (RST) begin
			if_cfg_st_q <= IF_CFG_RST;
			mode_st_q   <= DEV_MODE_RST;
			stream_st_q <= STREAM_RST;
			align_st_q  <= ALIGN_RST;
		end else if (cs_fall && state_q == S_IDLE) begin
			if_cfg_st_q <= if_cfg_q;
			mode_st_q   <= mode_q;
			stream_st_q <= stream_q;
			align_st_q  <= align_q;
		end else if (wr_byte) begin
			// a partial byte never reaches the staging copy
			case (addr_q)
				ADDR_IF_CFG: if_cfg_st_q <= wr_data;
				ADDR_DEV_MODE: mode_st_q <= wr_data;
				ADDR_STREAM: stream_st_q <= wr_data;
				ADDR_ALIGN: align_st_q <= wr_data;
				default: ;
			endcase
		end
	end

	// live registers
	always_ff @(posedge CLK) begin
		if (RST || commit_reset) begin
			if_cfg_q <= IF_CFG_RST;
			mode_q   <= DEV_MODE_RST;
			stream_q <= STREAM_RST;
			align_q  <= ALIGN_RST;
		end else if (commit) begin
			// reset bit is never stored, so it reads back cleared
			if_cfg_q <= {1'b0, if_cfg_st_q[6:5], 1'b1, if_cfg_st_q[3:0]};
			// reserved mode codes are dropped, the old mode stays
			if (mode_st_q[MODE_MSB:0] == MODE_RSVD_A || mode_st_q[MODE_MSB:0] == MODE_RSVD_B)
				mode_q <= {mode_st_q[7:2], mode_q[MODE_MSB:0]};
			else
				mode_q <= mode_st_q;
			stream_q <= stream_st_q;
			align_q  <= align_st_q;
		end
	end

	// reset quiet time; frames started inside it are skipped
	always_ff @(posedge CLK) begin
		if (RST)
			rst_cnt_q <= 7'h00;
		else if (commit_reset)
			rst_cnt_q <= RESET_CYCLES;
		else if (busy)
			rst_cnt_q <= 7'(rst_cnt_q - 7'h1);
	end

	always_ff @(posedge CLK) begin
		if (RST)
			CHIP_RESET <= 1'b0;
		else
			CHIP_RESET <= commit_reset || (rst_cnt_q > 7'h01);
	end

	// configuration outputs, registered
	always_ff @(posedge CLK) begin
		if (RST) begin
			CFG <= '0;
		end else begin
			CFG.op_mode                  <= mode_q[MODE_MSB:0];
			// processor gated by receiver, a guard against wrong order
			CFG.align_event_processor_on <= align_q[ALIGN_PROC_BIT] & align_q[ALIGN_RECV_BIT];
			CFG.align_receiver_on        <= align_q[ALIGN_RECV_BIT];
			CFG.window_fine_step         <= align_q[ALIGN_FINE_BIT];
			CFG.align_delay_choice       <= align_q[ALIGN_SEL_MSB:0];
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	a_reset_restores_all: assert property (
		commit_reset |=> if_cfg_q == IF_CFG_RST && align_q == ALIGN_RST
			&& mode_q == DEV_MODE_RST && stream_q == STREAM_RST)
		else $error("full-chip reset left a register set");
	a_reset_self_ends: assert property (
		commit_reset |=> CHIP_RESET && !if_cfg_q[IF_RESET_BIT] ##92 CHIP_RESET ##1 !CHIP_RESET && !busy)
		else $error("reset length or self clear wrong");
	a_addr_ascend_step: assert property (
		byte_end && !stream_q[STREAM_HOLD_BIT] && if_cfg_q[IF_ASCEND_BIT]
			|=> addr_q == 15'($past(addr_q) + 15'h1))
		else $error("address did not increment");
	a_addr_descend_step: assert property (
		byte_end && !stream_q[STREAM_HOLD_BIT] && !if_cfg_q[IF_ASCEND_BIT]
			|=> addr_q == 15'($past(addr_q) - 15'h1))
		else $error("address did not decrement");
	a_addr_hold_fixed: assert property (
		byte_end && stream_q[STREAM_HOLD_BIT] |=> $stable(addr_q))
		else $error("held address moved");
	a_sepout_reads_one: assert property (
		hdr_end && shift_q[14] && hdr_addr == ADDR_IF_CFG |=> rd_q[IF_SEPOUT_BIT])
		else $error("separate output flag read zero");
	a_mode_no_reserved: assert property (
		commit && !commit_reset && (mode_st_q[MODE_MSB:0] == MODE_RSVD_A
			|| mode_st_q[MODE_MSB:0] == MODE_RSVD_B) |=> $stable(mode_q[MODE_MSB:0]))
		else $error("reserved mode code accepted");
	a_proc_needs_recv: assert property (
		CFG.align_event_processor_on |-> $past(align_q[ALIGN_PROC_BIT]) && CFG.align_receiver_on)
		else $error("processor on without enable or receiver");
	a_recv_follows_bit: assert property (
		##1 CFG.align_receiver_on == $past(align_q[ALIGN_RECV_BIT]))
		else $error("receiver output mismatch");
	a_window_fields_out: assert property (
		##1 CFG.window_fine_step == $past(align_q[ALIGN_FINE_BIT])
			&& CFG.align_delay_choice == $past(align_q[ALIGN_SEL_MSB:0]))
		else $error("window fields mismatch");
	a_position_readback: assert property (
		hdr_end && hdr_addr == ADDR_POS0 |=> rd_q == $past(ALIGN_EDGE_POSITION[7:0]))
		else $error("edge position read wrong");
	a_commit_only_end: assert property (
		!commit |=> $stable(align_q) && $stable(mode_q) && $stable(stream_q) && $stable(if_cfg_q))
		else $error("register changed outside commit");

	c_soft_reset: cover property (commit_reset);
	c_id_read: cover property (hdr_end && shift_q[14] && hdr_addr == ADDR_ID_LO);
	c_stream_write: cover property (wr_byte && wr_seen_q);
	c_power_down: cover property (commit ##1 mode_q[MODE_MSB:0] == MODE_POWER_DOWN);
endmodule : cfg_regs
`default_nettype wire

/* File: core/cfg_pkg.sv */
`default_nettype none
package cfg_pkg;
	// register byte addresses
	localparam logic [14:0] ADDR_IF_CFG   = 15'h0000;
	localparam logic [14:0] ADDR_DEV_MODE = 15'h0002;
	localparam logic [14:0] ADDR_ID_LO    = 15'h000c;
	localparam logic [14:0] ADDR_ID_HI    = 15'h000d;
	localparam logic [14:0] ADDR_STREAM   = 15'h0010;
	localparam logic [14:0] ADDR_ALIGN    = 15'h0029;
	localparam logic [14:0] ADDR_POS0     = 15'h002c;
	localparam logic [14:0] ADDR_POS1     = 15'h002d;
	localparam logic [14:0] ADDR_POS2     = 15'h002e;

	// reset values
	localparam logic [7:0] IF_CFG_RST   = 8'h30;
	localparam logic [7:0] DEV_MODE_RST = 8'h00;
	localparam logic [7:0] STREAM_RST   = 8'h00;
	localparam logic [7:0] ALIGN_RST    = 8'h80;

	// field positions
	localparam int IF_RESET_BIT    = 7;
	localparam int IF_ASCEND_BIT   = 5;
	localparam int IF_SEPOUT_BIT   = 4;
	localparam int STREAM_HOLD_BIT = 0;
	localparam int ALIGN_PROC_BIT  = 6;
	localparam int ALIGN_RECV_BIT  = 5;
	localparam int ALIGN_FINE_BIT  = 4;
	localparam int ALIGN_SEL_MSB   = 3;
	localparam int MODE_MSB        = 1;

	// operating mode codes
	localparam logic [1:0] MODE_NORMAL     = 2'h0;
	localparam logic [1:0] MODE_RSVD_A     = 2'h1;
	localparam logic [1:0] MODE_RSVD_B     = 2'h2;
	localparam logic [1:0] MODE_POWER_DOWN = 2'h3;

	// serial framing
	localparam logic [3:0] HDR_LAST_BIT  = 4'hf;
	localparam logic [3:0] BYTE_LAST_BIT = 4'h7;

	// full-chip reset duration
	localparam int RESET_TIME_NS = 750;
	localparam int CLK_PERIOD_NS = 8;
	localparam logic [6:0] RESET_CYCLES = 7'(RESET_TIME_NS / CLK_PERIOD_NS);

	typedef enum logic [1:0] {
		S_IDLE,
		S_HDR,
		S_DATA,
		S_SKIP
	} spi_state_e;

	typedef struct packed {
		logic [1:0] op_mode;
		logic       align_event_processor_on;
		logic       align_receiver_on;
		logic       window_fine_step;
		logic [3:0] align_delay_choice;
	} cfg_s;
endpackage : cfg_pkg
`default_nettype wire

/* File: core/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int              W    = 1,
	parameter logic [W-1:0]    INIT = '0
) (
	input  wire logic          CLK,
	input  wire logic          RST,
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);
	logic [W-1:0] meta_q;

	// two-stage sampler; only the second stage is visible outside
	always_ff @(posedge CLK) begin
		if (RST) begin
			meta_q <= INIT;
			q      <= INIT;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : pin_sync
`default_nettype wire

/* File: tb/spi_host.sv */
`timescale 1ns/1ns
`default_nettype none
// host end of the four-wire link; serial clock idles low between frames
module spi_host (
	output logic      SCLK,
	output logic      CS_N,
	output logic      SDI,
	input  wire logic SDO
);
	// idle levels from time zero
	initial begin
		SCLK = 1'b0;
		CS_N = 1'b1;
		SDI  = 1'b0;
	end
	// one frame: header then nbits data bits, msb first
	// read bits taken from the separate output
	task automatic frame(input logic rd, input logic [14:0] addr, input int nbits,
		input logic [31:0] wdata, output logic [31:0] rdata);
		logic [15:0] hdr;
		hdr   = {rd, addr};
		rdata = 32'h0;
		CS_N  = 1'b0;
		#64;
		for (int i = 15 + nbits; i >= 0; i--) begin
			SDI = (i >= nbits) ? hdr[i - nbits] : wdata[i];
			#32 SCLK = 1'b1;
			// sampled late in the high phase, where the output bit has settled
			#30 if (i < nbits) rdata = {rdata[30:0], SDO};
			#2 SCLK = 1'b0;
		end
		#32 CS_N = 1'b1;
		SDI = ~SDI; // released line: never leave a stale data bit
		#64;
	endtask : frame
endmodule : spi_host
`default_nettype wire

/* File: tb/cfg_regs_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module cfg_regs_tb_top;
	import cfg_pkg::*;
	localparam logic [15:0] ID = 16'h3c69; // arbitrary value
	localparam int LIMIT = 20000;
	localparam logic [14:0] AD [4] = '{ADDR_IF_CFG, ADDR_DEV_MODE, ADDR_STREAM, ADDR_ALIGN};
	localparam logic [7:0]  RV [4] = '{IF_CFG_RST, DEV_MODE_RST, STREAM_RST, ALIGN_RST};
	localparam logic [1:0]  MC [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
	localparam logic [1:0]  ME [4] = '{2'h3, 2'h3, 2'h3, 2'h0};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [23:0] pos = 24'h0;
	logic        sclk;
	logic        cs_n;
	logic        sdi;
	logic        sdo;
	logic        chip_reset;
	cfg_s        cfg;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          hi_cnt = 0;

	cfg_regs #(.MAKER_ID(ID)) cfg_regs_i (
		.CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo),
		.ALIGN_EDGE_POSITION(pos), .CFG(cfg), .CHIP_RESET(chip_reset)
	);
	spi_host spi_host_i (.SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO(sdo));

	// free-running system clock
	always #4 clk = ~clk;

	// length of the reset pulse, and a hang guard
	always @(posedge clk) begin
		cycles++;
		if (chip_reset === 1'b1) hi_cnt <= hi_cnt + 1;
		if (cycles == LIMIT) begin
			num_errors++;
			conclude();
		end
	end

	task automatic conclude;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	// link edges start just after a clock edge, never on it, so no race with the sampler
	task automatic xfer(input logic rw, input logic [14:0] a, input int nbits,
		input logic [31:0] wd, output logic [31:0] r);
		@(posedge clk);
		#1;
		spi_host_i.frame(rw, a, nbits, wd, r);
	endtask : xfer

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		logic [31:0] r;
		xfer(1'b0, a, 8, {24'h0, d}, r);
	endtask : wr

	task automatic rd(input logic [14:0] a, input int nbits, output logic [31:0] r);
		xfer(1'b1, a, nbits, 32'h0, r);
	endtask : rd

	// main sequence
	initial begin
		logic [31:0] r;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge clk);
		for (int k = 0; k < 4; k++) begin
			rd(AD[k], 8, r);
			`CHK(r[7:0], RV[k])
		end
		`CHK(cfg, 9'h000)
		rd(15'h0005, 8, r);
		`CHK(r[7:0], 8'h00)
		rd(ADDR_ID_LO, 16, r);
		`CHK(r[15:0], {ID[7:0], ID[15:8]})
		@(posedge clk);
		#1 pos = 24'ha5c381;
		rd(ADDR_POS0, 24, r);
		`CHK(r[23:0], 24'h81c3a5)
		// receiver first, reserved bit kept, zoom on
		wr(ADDR_ALIGN, 8'ha0);
		`CHK(cfg, 9'h020)
		wr(ADDR_ALIGN, 8'hf5);
		`CHK(cfg, 9'h075)
		// a frame cut off inside its byte must change nothing
		xfer(1'b0, ADDR_ALIGN, 7, 32'h0, r);
		`CHK(cfg, 9'h075)
		rd(ADDR_ALIGN, 8, r);
		`CHK(r[7:0], 8'hf5)
		// every mode code, reserved ones refused
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_DEV_MODE, {6'h0, MC[k]});
			`CHK(cfg, {ME[k], 7'h75})
			rd(ADDR_DEV_MODE, 8, r);
			`CHK(r[7:0], {6'h0, ME[k]})
		end
		// descending stream, then held address
		wr(ADDR_IF_CFG, 8'h00);
		rd(ADDR_ID_HI, 16, r);
		`CHK(r[15:0], ID)
		rd(ADDR_IF_CFG, 8, r);
		`CHK(r[7:0], 8'h10)
		wr(ADDR_STREAM, 8'h01);
		rd(ADDR_ALIGN, 16, r);
		`CHK(r[15:0], 16'hf5f5)
		// soft reset, then at least 750 ns of silence
		wr(ADDR_IF_CFG, 8'h80);
		repeat (100) @(posedge clk);
		`CHK(hi_cnt, int'(RESET_CYCLES))
		`CHK(chip_reset, 1'b0)
		`CHK(cfg, 9'h000)
		rd(ADDR_IF_CFG, 8, r);
		`CHK(r[7:0], 8'h30)
		rd(ADDR_STREAM, 16, r);
		`CHK(r[15:0], 16'h0000)
		rd(ADDR_ALIGN, 8, r);
		`CHK(r[7:0], 8'h80)
		conclude();
	end
endmodule : cfg_regs_tb_top
`default_nettype wire
